//--- core/clp_pkg.sv
// Package for the core low-power state controller: register offsets, field
// positions, reset values, state enumerations and timing counts.
// Assumes a 50 MHz platform clock and a byte-addressed 32-bit register port.
package clp_pkg;

   // Platform clock period and the time figures derived from it.
   localparam int CLK_PERIOD_NS = 20;
   localparam int WAKE_LIMIT_CLKS = 100;
   localparam int WAKE_CYCLES = WAKE_LIMIT_CLKS;
   localparam int ENTRY_CYCLES = 4;
   localparam int QM_STEP_CYCLES = 16;

   // Register bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register offsets (byte addresses, one aligned word each).
   localparam logic [7:0] REG_PM_ENTER = 8'h00;
   localparam logic [7:0] REG_PM_WAKE = 8'h04;
   localparam logic [7:0] REG_CLK_DISABLE = 8'h08;
   localparam logic [7:0] REG_CLUSTER = 8'h0C;
   localparam logic [7:0] REG_QM_MEMBERS = 8'h10;
   localparam logic [7:0] REG_QM_NAP_LEVEL = 8'h14;
   localparam logic [7:0] REG_QM_WAKE_LEVEL = 8'h18;
   localparam logic [7:0] REG_CORE_STATUS = 8'h1C;
   localparam logic [7:0] REG_VOLT_CODE = 8'h20;
   localparam logic [7:0] REG_LINK_STATUS = 8'h24;

   // Field positions.
   localparam int F_TARGET_LSB = 0;
   localparam int F_TARGET_W = 4;
   localparam int F_STATE_LSB = 8;
   localparam int F_STATE_W = 2;
   localparam int F_CL_NAP = 0;
   localparam int F_CL_WAKE = 1;
   localparam int F_CL_ACTIVE = 2;
   localparam int CORE_STATUS_W = 4;

   // Requested low-power state codes in the entry register.
   localparam logic [1:0] REQ_DOZE = 2'h1;
   localparam logic [1:0] REQ_NAP = 2'h2;

   // Reset values.
   localparam logic [15:0] QM_NAP_LEVEL_RST = 16'h0004;
   localparam logic [15:0] QM_WAKE_LEVEL_RST = 16'h0040;

   // Per-core power states.
   typedef enum logic [2:0] {
      CORE_RUN,
      CORE_DOZE,
      CORE_NAP_ENTER,
      CORE_NAP,
      CORE_WAKING
   } clp_core_state_type;

   // Cluster power states.
   typedef enum logic [1:0] {
      CL_RUN,
      CL_NAP,
      CL_WAKING
   } clp_cl_state_type;

endpackage

//--- core/clp_core_ctl.sv
// One core's low-power sequencer: light doze, deep nap, entry and wake-up.
// Assumes all inputs come from logic on the platform clock; the top level
// decides which register wakes are legal before they reach this module.
`timescale 1ns/1ps
module clp_core_ctl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic reg_doze,
   input wire logic reg_nap,
   input wire logic reg_wake,
   input wire logic [1:0] thread_wait,
   input wire logic hw_wake,
   input wire logic cluster_hold,
   output logic fetch_en,
   output logic snoop_en,
   output logic core_clk_on,
   output logic retention_en,
   output logic [1:0] thread_halted,
   output logic in_doze,
   output logic [clp_pkg::CORE_STATUS_W-1:0] status
);
   import clp_pkg::*;

   clp_core_state_type state;
   logic by_reg;
   logic wake_pending;
   logic [7:0] count;
   logic wake_now;

   // A register-placed core ignores its own hardware wake sources.
   assign wake_now = reg_wake | (hw_wake & ~by_reg);

   // Main sequencer; nothing moves while the cluster holds the clocks off.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= CORE_RUN;
         by_reg <= 1'b0;
         wake_pending <= 1'b0;
         count <= 8'h00;
      end else if (ce && !cluster_hold) begin
         case (state)
            CORE_RUN: begin
               wake_pending <= 1'b0;
               if (reg_nap) begin
                  state <= CORE_NAP_ENTER;
                  by_reg <= 1'b1;
                  count <= 8'h00;
               end else if (reg_doze) begin
                  state <= CORE_DOZE;
                  by_reg <= 1'b1;
               end else if (&thread_halted) begin
                  state <= CORE_NAP_ENTER;
                  by_reg <= 1'b0;
                  count <= 8'h00;
               end
            end
            CORE_DOZE: begin
               if (reg_nap) begin
                  state <= CORE_NAP_ENTER;
                  count <= 8'h00;
               end else if (wake_now) begin
                  state <= CORE_RUN;
                  by_reg <= 1'b0;
               end
            end
            CORE_NAP_ENTER: begin
               // A wake during entry is held and served once entry completes.
               if (wake_now) begin
                  wake_pending <= 1'b1;
               end
               if (count == 8'(ENTRY_CYCLES - 1)) begin
                  count <= 8'h00;
                  state <= (wake_pending || wake_now) ? CORE_WAKING : CORE_NAP;
               end else begin
                  count <= count + 8'h01;
               end
            end
            CORE_NAP: begin
               wake_pending <= 1'b0;
               if (wake_now) begin
                  state <= CORE_WAKING;
                  count <= 8'h00;
               end
            end
            CORE_WAKING: begin
               if (count == 8'(WAKE_CYCLES - 1)) begin
                  state <= CORE_RUN;
                  by_reg <= 1'b0;
                  count <= 8'h00;
               end else begin
                  count <= count + 8'h01;
               end
            end
            default: begin
               state <= CORE_RUN;
            end
         endcase
      end
   end

   // Per-thread halt flags; a wake event releases both threads. A halt in the same cycle as a hardware
   // wake in run still counts, but while waking the flags follow thread_wait, so only a last-cycle halt stays.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         thread_halted <= 2'b00;
      end else if (ce) begin
         if (state == CORE_WAKING || (state == CORE_RUN && hw_wake)) begin
            thread_halted <= thread_wait;
         end else begin
            thread_halted <= thread_halted | thread_wait;
         end
      end
   end

   // Doze keeps snoops and state; nap stops everything under retention.
   assign fetch_en = (state == CORE_RUN) && !cluster_hold && !(&thread_halted);
   assign snoop_en = (state == CORE_RUN || state == CORE_DOZE) && !cluster_hold;
   assign core_clk_on = (state != CORE_NAP) && !cluster_hold;
   assign retention_en = (state == CORE_NAP) || cluster_hold;
   assign in_doze = (state == CORE_DOZE);
   assign status = {retention_en, ~core_clk_on, ~snoop_en, ~fetch_en};

endmodule

//--- core/clp_top.sv
// Core low-power state controller: block clock gating, static clock
// disable, link idle signalling, voltage code, per-core and cluster power
// states and load-driven nap/wake hints for one pool channel.
// Assumes one platform clock; the voltage code pins are asynchronous.
`timescale 1ns/1ps
module clp_top #(
   parameter int NUM_CORES = 4,
   parameter int NUM_BLOCKS = 8,
   parameter int LPI_IDLE_CYCLES = 50000,
   parameter int VCODE_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [clp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [clp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_writer_core,
   output logic [clp_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [NUM_BLOCKS-1:0] blk_work,
   input wire logic [NUM_BLOCKS-1:0] blk_busy,
   output logic [NUM_BLOCKS-1:0] blk_clk_en,
   input wire logic tx_active,
   output logic lpi_req,
   input wire logic [VCODE_W-1:0] vcode_pin,
   input wire logic [2*NUM_CORES-1:0] thread_wait,
   input wire logic [NUM_CORES-1:0] ext_trigger,
   input wire logic [NUM_CORES-1:0] irq,
   input wire logic [NUM_CORES-1:0] doorbell,
   input wire logic [NUM_CORES-1:0] l1_stash,
   input wire logic [NUM_CORES-1:0] resv_lost,
   input wire logic l2_flushed,
   output logic [NUM_CORES-1:0] fetch_en,
   output logic [NUM_CORES-1:0] snoop_en,
   output logic [NUM_CORES-1:0] core_clk_en,
   output logic [NUM_CORES-1:0] retention_en,
   output logic cluster_nap,
   input wire logic [15:0] pool_depth,
   output logic [2*NUM_CORES-1:0] qm_nap_hint
);
   import clp_pkg::*;

   localparam int NT = 2 * NUM_CORES;

   logic [NUM_BLOCKS+NUM_CORES-1:0] clk_off;
   logic [NUM_CORES-1:0] enter_doze;
   logic [NUM_CORES-1:0] enter_nap;
   logic [NUM_CORES-1:0] reg_wake;
   logic [NUM_CORES-1:0] hw_wake;
   logic [NUM_CORES-1:0] in_doze;
   logic [NUM_CORES-1:0] core_clk_on;
   logic [NT-1:0] thread_halted;
   logic [NUM_CORES*CORE_STATUS_W-1:0] core_status;
   logic [NT-1:0] qm_members;
   logic [15:0] qm_nap_level;
   logic [15:0] qm_wake_level;
   logic [NT-1:0] qm_wake;
   logic [NUM_CORES-1:0] qm_core_wake;
   logic [7:0] qm_step;
   logic [31:0] idle_count;
   logic [VCODE_W-1:0] vcode_meta;
   logic [VCODE_W-1:0] vcode_sync;
   logic [VCODE_W-1:0] volt_code;
   logic vcode_taken;
   logic [1:0] vcode_settle;
   clp_cl_state_type cl_state;
   logic [7:0] cl_count;
   logic [F_TARGET_W-1:0] wr_target;
   logic [F_STATE_W-1:0] wr_state;
   logic wr_enter;
   logic wr_wake;

   assign wr_target = reg_wdata[F_TARGET_LSB +: F_TARGET_W];
   assign wr_state = reg_wdata[F_STATE_LSB +: F_STATE_W];
   assign wr_enter = ce && reg_wr && reg_addr == REG_PM_ENTER;
   assign wr_wake = ce && reg_wr && reg_addr == REG_PM_WAKE;

   // Static clock disable bits can only be set; clearing needs a chip reset.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clk_off <= '0;
      end else if (ce && reg_wr && reg_addr == REG_CLK_DISABLE) begin
         clk_off <= clk_off | reg_wdata[NUM_BLOCKS+NUM_CORES-1:0];
      end
   end

   // Registered gate: work seen this cycle turns the clock on next cycle.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blk_clk_en <= '0;
      end else if (ce) begin
         blk_clk_en <= ~clk_off[NUM_BLOCKS-1:0] & (blk_work | blk_busy);
      end
   end

   // Transmit idle counter; the count saturates so the request holds.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idle_count <= 32'h0000_0000;
         lpi_req <= 1'b0;
      end else if (ce) begin
         if (tx_active) begin
            idle_count <= 32'h0000_0000;
            lpi_req <= 1'b0;
         end else if (idle_count >= 32'(LPI_IDLE_CYCLES - 1)) begin
            lpi_req <= 1'b1;
         end else begin
            idle_count <= idle_count + 32'h0000_0001;
         end
      end
   end

   // Voltage code pins are asynchronous, so two flops precede the capture.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         vcode_meta <= '0;
         vcode_sync <= '0;
         vcode_settle <= 2'b00;
      end else if (ce) begin
         vcode_meta <= vcode_pin;
         vcode_sync <= vcode_meta;
         vcode_settle <= {vcode_settle[0], 1'b1};
      end
   end

   // The code is caught once after reset release, three edges in to let the
   // synchroniser settle; later pin noise cannot disturb it.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         volt_code <= '0;
         vcode_taken <= 1'b0;
      end else if (ce && !vcode_taken && vcode_settle[1]) begin
         volt_code <= vcode_sync;
         vcode_taken <= 1'b1;
      end
   end

   // Register entry and wake decode; a core may not wake itself.
   always_comb begin
      enter_doze = '0;
      enter_nap = '0;
      reg_wake = '0;
      for (int c = 0; c < NUM_CORES; c++) begin
         if (wr_enter && wr_target == F_TARGET_W'(c)) begin
            enter_doze[c] = (wr_state == REQ_DOZE);
            enter_nap[c] = (wr_state == REQ_NAP);
         end
         if (wr_wake && wr_target == F_TARGET_W'(c) && reg_writer_core != 4'(c)) begin
            reg_wake[c] = 1'b1;
         end
      end
   end

   // Hardware wake sources for halt-until-event exit.
   assign hw_wake = ext_trigger | irq | doorbell | l1_stash | resv_lost | qm_core_wake;

   // One sequencer per core.
   for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
      logic clk_on_seq;
      clp_core_ctl u_core (
         .clk(clk),
         .rst_n(rst_n),
         .ce(ce),
         .reg_doze(enter_doze[c]),
         .reg_nap(enter_nap[c]),
         .reg_wake(reg_wake[c]),
         .thread_wait(thread_wait[2*c +: 2]),
         .hw_wake(hw_wake[c]),
         .cluster_hold(cluster_nap),
         .fetch_en(fetch_en[c]),
         .snoop_en(snoop_en[c]),
         .core_clk_on(clk_on_seq),
         .retention_en(retention_en[c]),
         .thread_halted(thread_halted[2*c +: 2]),
         .in_doze(in_doze[c]),
         .status(core_status[c*CORE_STATUS_W +: CORE_STATUS_W])
      );
      assign core_clk_on[c] = clk_on_seq;
      assign core_clk_en[c] = clk_on_seq && !clk_off[NUM_BLOCKS + c];
   end

   // Cluster nap needs every core dozing and the L2 flushed; wake-up takes
   // the same restart time as a single core.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cl_state <= CL_RUN;
         cl_count <= 8'h00;
      end else if (ce) begin
         case (cl_state)
            CL_RUN: begin
               if (reg_wr && reg_addr == REG_CLUSTER && reg_wdata[F_CL_NAP] &&
                   (&in_doze) && l2_flushed) begin
                  cl_state <= CL_NAP;
               end
            end
            CL_NAP: begin
               if (reg_wr && reg_addr == REG_CLUSTER && reg_wdata[F_CL_WAKE]) begin
                  cl_state <= CL_WAKING;
                  cl_count <= 8'h00;
               end
            end
            CL_WAKING: begin
               if (cl_count == 8'(WAKE_CYCLES - 1)) begin
                  cl_state <= CL_RUN;
               end else begin
                  cl_count <= cl_count + 8'h01;
               end
            end
            default: begin
               cl_state <= CL_RUN;
            end
         endcase
      end
   end

   assign cluster_nap = (cl_state != CL_RUN);

   // Pool channel configuration registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         qm_members <= '0;
         qm_nap_level <= QM_NAP_LEVEL_RST;
         qm_wake_level <= QM_WAKE_LEVEL_RST;
      end else if (ce && reg_wr) begin
         if (reg_addr == REG_QM_MEMBERS) begin
            qm_members <= reg_wdata[NT-1:0];
         end
         if (reg_addr == REG_QM_NAP_LEVEL) begin
            qm_nap_level <= reg_wdata[15:0];
         end
         if (reg_addr == REG_QM_WAKE_LEVEL) begin
            qm_wake_level <= reg_wdata[15:0];
         end
      end
   end

   // Load-driven hints, one step per interval so the load can react before
   // the next thread is told to nap or woken.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         qm_nap_hint <= '0;
         qm_wake <= '0;
         qm_step <= 8'h00;
      end else if (ce) begin
         qm_wake <= '0;
         if (qm_step != 8'h00) begin
            qm_step <= qm_step - 8'h01;
         end else if (pool_depth > qm_wake_level) begin
            for (int t = NT - 1; t >= 0; t--) begin
               if (qm_members[t] && thread_halted[t]) begin
                  qm_wake <= NT'(1) << t;
               end
            end
            qm_nap_hint <= '0;
            qm_step <= 8'(QM_STEP_CYCLES - 1);
         end else if (pool_depth <= qm_nap_level) begin
            for (int t = 0; t < NT; t++) begin
               if (qm_members[t] && !qm_nap_hint[t] && !thread_halted[t] &&
                   !(|(qm_members & ~qm_nap_hint & ~thread_halted & ~(NT'(1) << t) &
                     ~((NT'(1) << t) - NT'(1))))) begin
                  qm_nap_hint[t] <= 1'b1;
               end
            end
            qm_step <= 8'(QM_STEP_CYCLES - 1);
         end
      end
   end

   // Fold the per-thread wake pulse onto its core.
   always_comb begin
      for (int c = 0; c < NUM_CORES; c++) begin
         qm_core_wake[c] = qm_wake[2*c] | qm_wake[2*c+1];
      end
   end

   // Read port: data stands the cycle after the strobe; unmapped reads zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               REG_CLK_DISABLE: reg_rdata <= 32'(clk_off);
               REG_CLUSTER: reg_rdata <= 32'({cluster_nap, 2'b00});
               REG_QM_MEMBERS: reg_rdata <= 32'(qm_members);
               REG_QM_NAP_LEVEL: reg_rdata <= {16'h0000, qm_nap_level};
               REG_QM_WAKE_LEVEL: reg_rdata <= {16'h0000, qm_wake_level};
               REG_CORE_STATUS: reg_rdata <= 32'(core_status);
               REG_VOLT_CODE: reg_rdata <= 32'(volt_code);
               REG_LINK_STATUS: reg_rdata <= 32'({lpi_req, thread_halted});
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

endmodule

//--- sim/clp_checker.sv
// Concurrent checks on the ports of the low-power controller top level.
// Assumes one platform clock and the bind statement at the foot of this file.
`timescale 1ns/1ps
module clp_checker
   import clp_pkg::*;
#(
   parameter int NUM_CORES = 4,
   parameter int NUM_BLOCKS = 8,
   parameter int LPI_IDLE_CYCLES = 50000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [clp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [clp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [3:0] reg_writer_core,
   input wire logic [NUM_BLOCKS-1:0] blk_work,
   input wire logic [NUM_BLOCKS-1:0] blk_busy,
   input wire logic [NUM_BLOCKS-1:0] blk_clk_en,
   input wire logic tx_active,
   input wire logic lpi_req,
   input wire logic [NUM_CORES-1:0] fetch_en,
   input wire logic [NUM_CORES-1:0] snoop_en,
   input wire logic [NUM_CORES-1:0] core_clk_en,
   input wire logic [NUM_CORES-1:0] retention_en,
   input wire logic cluster_nap
);
   int idle_cnt;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Idle transmit cycles; saturates so a long quiet run cannot wrap it.
   always_ff @(posedge clk) begin
      if (!rst_n || tx_active) begin
         idle_cnt <= 0;
      end else if (ce && idle_cnt < 100000) begin
         idle_cnt <= idle_cnt + 1;
      end
   end

   // Register wake of napping core 1 by another core, then its return.
   sequence s_wake1;
      ce && reg_wr && reg_addr == REG_PM_WAKE && reg_wdata[3:0] == 4'h1
         && reg_writer_core != 4'h1 && retention_en[1];
   endsequence
   sequence s_return1;
      (!fetch_en[1]) [*8] ##[85:100] fetch_en[1];
   endsequence
   sequence s_nap1;
      ce && reg_wr && reg_addr == REG_PM_ENTER && reg_wdata[9:0] == 10'h201
         && fetch_en[1] && !cluster_nap;
   endsequence

   blk_wake_a: assert property (ce && blk_work[0] |=> blk_clk_en[0])
      else $error("block clock not back after work");
   blk_idle_a: assert property (ce && !blk_work[0] && !blk_busy[0] |=> !blk_clk_en[0])
      else $error("idle block clock still running");
   lpi_drop_a: assert property (ce && tx_active |=> !lpi_req)
      else $error("idle request held during transmit");
   lpi_idle_a: assert property (idle_cnt > LPI_IDLE_CYCLES + 2 |-> lpi_req)
      else $error("idle request missing after long quiet");
   doze_entry_a: assert property (ce && reg_wr && reg_addr == REG_PM_ENTER
      && reg_wdata[9:0] == 10'h100 && fetch_en[0] && !cluster_nap
      |=> !fetch_en[0] && snoop_en[0] && core_clk_en[0])
      else $error("doze entry wrong");
   nap_entry_a: assert property (s_nap1 |=> !snoop_en[1] ##[3:5] (!core_clk_en[1] && retention_en[1]))
      else $error("nap entry wrong");
   fetch_snoop_a: assert property ((fetch_en & ~snoop_en) == '0)
      else $error("fetching while snoops stopped");
   retain_off_a: assert property ((retention_en & (core_clk_en | snoop_en | fetch_en)) == '0)
      else $error("retention with core active");
   self_wake_a: assert property (ce && reg_wr && reg_addr == REG_PM_WAKE
      && reg_wdata[3:0] == 4'h1 && reg_writer_core == 4'h1 && retention_en[1]
      |=> retention_en[1] [*4])
      else $error("core woke itself");
   wake_time_a: assert property (s_wake1 |=> s_return1)
      else $error("nap wake time out of bound");
endmodule

bind clp_top clp_checker #(
   .NUM_CORES(NUM_CORES),
   .NUM_BLOCKS(NUM_BLOCKS),
   .LPI_IDLE_CYCLES(LPI_IDLE_CYCLES)
) u_clp_checker (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_writer_core,
   .blk_work, .blk_busy, .blk_clk_en, .tx_active, .lpi_req, .fetch_en, .snoop_en,
   .core_clk_en, .retention_en, .cluster_nap);

//--- sim/clp_far_model.sv
// Far-side model: hardware threads and wake sources of four cores.
// Assumes the bench raises a request for one cycle; each becomes one pulse.
`timescale 1ns/1ps
module clp_far_model (
   input wire logic clk,
   input wire logic [7:0] halt,
   input wire logic [4:0] ev,
   input wire logic [3:0] ev_core,
   output logic [7:0] thread_wait,
   output logic [3:0] ext_trigger,
   output logic [3:0] irq,
   output logic [3:0] doorbell,
   output logic [3:0] l1_stash,
   output logic [3:0] resv_lost
);
   // Quiet at time zero so the design never sees an unknown event.
   initial begin
      {thread_wait, ext_trigger, irq, doorbell, l1_stash, resv_lost} = '0;
   end

   // Each thread reports its halt instruction alone, one pulse per thread.
   always @(posedge clk) begin
      thread_wait <= halt;
   end

   // Wake sources pulse only towards the cores that the bench names.
   always @(posedge clk) begin
      ext_trigger <= ev[0] ? ev_core : 4'h0;
      irq <= ev[1] ? ev_core : 4'h0;
      doorbell <= ev[2] ? ev_core : 4'h0;
      l1_stash <= ev[3] ? ev_core : 4'h0;
      resv_lost <= ev[4] ? ev_core : 4'h0;
   end
endmodule

//--- sim/clp_top_tb.sv
// Self-checking bench for the low-power controller top level.
// Assumes the far-side model beside it and the checker bound into the design.
`timescale 1ns/1ps
module clp_top_tb;
   import clp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] reg_writer_core = 4'h0;
   logic [31:0] reg_rdata;
   logic [7:0] blk_work = 8'h00;
   logic [7:0] blk_busy = 8'h00;
   logic [7:0] blk_clk_en;
   logic tx_active = 1'b1;
   logic lpi_req;
   logic [7:0] vcode_pin = 8'h5A;
   logic [7:0] halt = 8'h00;
   logic [4:0] ev = 5'h00;
   logic [3:0] ev_core = 4'h0;
   logic [7:0] thread_wait;
   logic [3:0] ext_trigger, irq, doorbell, l1_stash, resv_lost;
   logic l2_flushed = 1'b0;
   logic [3:0] fetch_en, snoop_en, core_clk_en, retention_en;
   logic cluster_nap;
   logic [15:0] pool_depth = 16'h0000;
   logic [7:0] qm_nap_hint;
   int num_errors = 0;
   int n_tests = 0;

   // Platform clock, 20 ns period.
   always #10 clk = ~clk;

   clp_top #(.LPI_IDLE_CYCLES(20)) u_clp_top (.clk, .rst_n, .ce, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_writer_core, .reg_rdata, .blk_work, .blk_busy, .blk_clk_en,
      .tx_active, .lpi_req, .vcode_pin, .thread_wait, .ext_trigger, .irq, .doorbell,
      .l1_stash, .resv_lost, .l2_flushed, .fetch_en, .snoop_en, .core_clk_en,
      .retention_en, .cluster_nap, .pool_depth, .qm_nap_hint);
   clp_far_model u_clp_far_model (.clk, .halt, .ev, .ev_core, .thread_wait,
      .ext_trigger, .irq, .doorbell, .l1_stash, .resv_lost);

   task automatic results;
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One write cycle; the next call waits an edge, so strobes never merge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] w);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      reg_writer_core <= w;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the read edge.
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk_val(reg_rdata, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic fire(input logic [7:0] h, input logic [4:0] e, input logic [3:0] c);
      @(posedge clk);
      halt <= h;
      ev <= e;
      ev_core <= c;
      @(posedge clk);
      halt <= 8'h00;
      ev <= 5'h00;
   endtask

   task automatic wait_hint(input logic [7:0] old);
      for (int i = 0; i < 40 && qm_nap_hint === old; i++) begin
         cyc(1);
      end
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (6000) @(posedge clk);
      num_errors++;
      results();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, an unmapped place and the factory code.
      chk_reg(REG_QM_NAP_LEVEL, 32'h4);
      chk_reg(REG_QM_WAKE_LEVEL, 32'h40);
      chk_reg(REG_CORE_STATUS, 32'h0);
      chk_reg(8'hFC, 32'h0);
      chk_reg(REG_VOLT_CODE, 32'h5A);
      // Work wakes a gated block for exactly the next cycle.
      @(posedge clk);
      blk_work <= 8'h01;
      @(posedge clk);
      blk_work <= 8'h00;
      #1 chk_val(blk_clk_en, 8'h01);
      cyc(1);
      chk_val(blk_clk_en, 8'h00);
      // Static disable of block 7 and core 3 cannot be undone by software.
      wr(REG_CLK_DISABLE, 32'h880, 4'h0);
      wr(REG_CLK_DISABLE, 32'h0, 4'h0);
      chk_reg(REG_CLK_DISABLE, 32'h880);
      blk_work <= 8'hFF;
      cyc(2);
      chk_val(blk_clk_en, 8'h7F);
      chk_val(core_clk_en, 4'h7);
      blk_work <= 8'h00;
      tx_active <= 1'b0;
      ce <= 1'b0;
      cyc(25);
      chk_val(lpi_req, 1'b0);
      ce <= 1'b1;
      cyc(30);
      chk_val(lpi_req, 1'b1);
      tx_active <= 1'b1;
      cyc(1);
      chk_val(lpi_req, 1'b0);
      // Core 0 dozes itself; interrupts cannot end a register entry.
      wr(REG_PM_ENTER, 32'h100, 4'h0);
      #1 chk_val({snoop_en[0], fetch_en[0]}, 2'h2);
      chk_reg(REG_CORE_STATUS, 32'h1);
      fire(8'h00, 5'h02, 4'h1);
      cyc(3);
      chk_val(fetch_en, 4'hE);
      wr(REG_PM_WAKE, 32'h0, 4'h2);
      #1 chk_val(fetch_en, 4'hF);
      // Core 1 naps itself, ignores its own wake, returns in about 100 clocks.
      wr(REG_PM_ENTER, 32'h201, 4'h1);
      cyc(6);
      chk_val({retention_en[1], core_clk_en[1], snoop_en[1], fetch_en[1]}, 4'h8);
      chk_reg(REG_CORE_STATUS, 32'hF0);
      fire(8'h00, 5'h04, 4'h2);
      wr(REG_PM_WAKE, 32'h1, 4'h1);
      cyc(3);
      chk_val(retention_en, 4'h2);
      wr(REG_PM_WAKE, 32'h1, 4'h3);
      cyc(95);
      chk_val(fetch_en[1], 1'b0);
      cyc(8);
      chk_val(fetch_en[1], 1'b1);
      // Core 2 naps only when both threads halt; every event kind wakes it.
      for (int k = 0; k < 5; k++) begin
         fire(8'h10, 5'h00, 4'h0);
         cyc(8);
         chk_val(retention_en[2], 1'b0);
         fire(8'h20, 5'h00, 4'h0);
         cyc(8);
         chk_val(retention_en[2], 1'b1);
         fire(8'h00, 5'h01 << k, 4'h4);
         cyc(110);
         chk_val(fetch_en[2], 1'b1);
      end
      // A doorbell during entry is kept: entry completes, then wake follows.
      fire(8'h30, 5'h00, 4'h0);
      fire(8'h00, 5'h04, 4'h4);
      cyc(8);
      chk_val(fetch_en[2], 1'b0);
      cyc(110);
      chk_val(fetch_en[2], 1'b1);
      // With L2 flushed, cluster nap is refused until all cores doze.
      l2_flushed <= 1'b1;
      wr(REG_CLUSTER, 32'h1, 4'h0);
      cyc(2);
      chk_val(cluster_nap, 1'b0);
      for (int c = 0; c < 4; c++) begin
         wr(REG_PM_ENTER, 32'h100 | c, 4'h0);
      end
      wr(REG_CLUSTER, 32'h1, 4'h0);
      cyc(2);
      chk_val(cluster_nap, 1'b1);
      chk_reg(REG_CLUSTER, 32'h4);
      wr(REG_CLUSTER, 32'h2, 4'h0);
      cyc(110);
      chk_val(cluster_nap, 1'b0);
      l2_flushed <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr(REG_PM_WAKE, 32'(c), 4'(c ^ 1));
      end
      #1 chk_val(fetch_en, 4'hF);
      // Light load hints from the top member down; depth 0x41 wakes the lowest.
      wr(REG_QM_MEMBERS, 32'h3C, 4'h0);
      wait_hint(8'h00);
      chk_val(qm_nap_hint, 8'h20);
      wait_hint(8'h20);
      chk_val(qm_nap_hint, 8'h30);
      fire(8'h14, 5'h00, 4'h0);
      @(posedge clk);
      pool_depth <= 16'h0041;
      repeat (16) @(posedge clk);
      pool_depth <= 16'h0010;
      cyc(2);
      chk_val(qm_nap_hint, 8'h00);
      chk_reg(REG_LINK_STATUS, 32'h10);
      results();
   end
endmodule
